// *** dv/wrc_assertions.sv ***
`timescale 1ns/1ps
module wrc_assertions
    import wrc_pkg::*;
#(
    parameter int STARTUP_CYCLES = 20
) (
    // Clock and reset
    input wire logic                       core_clk,
    input wire logic                       rst_n,
    // Sources and requests
    input wire logic                       por_active,
    input wire logic                       ext_reset_pin_n,
    input wire logic                       ext_reset_enable,
    input wire logic                       supply_monitor_enable,
    input wire logic                       supply_low,
    input wire logic                       wdog_always_on_fuse,
    input wire logic                       comparator_ref_select,
    input wire logic                       adc_enable,
    // Processor side
    input wire logic                       ctrl_wr,
    input wire logic [wrc_pkg::CTRL_W-1:0] ctrl_wdata,
    input wire logic                       watchdog_restart_instr,
    input wire logic                       wdog_irq_ack,
    input wire logic                       wdog_reset_flag,
    // Outputs
    input wire logic [wrc_pkg::CTRL_W-1:0] ctrl_rdata,
    input wire logic                       sys_reset,
    input wire logic                       wdog_reset_pulse,
    input wire logic                       wdog_irq,
    input wire logic                       ref_enable
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    por_reset_a: assert property (por_active |-> sys_reset)
        else $error("no reset while power-on detector active");
    // Holds only while the stretch parameter is at least 8
    stretch_hold_a: assert property ($fell(por_active) |-> sys_reset [*8])
        else $error("reset released before stretch ran");
    pin_reset_a: assert property (ext_reset_enable && !ext_reset_pin_n |-> sys_reset)
        else $error("no reset while enabled pin low");
    ref_enable_a: assert property (ref_enable ==
        (supply_monitor_enable | comparator_ref_select | adc_enable))
        else $error("reference enable wrong");
    bod_filter_a: assert property ($rose(supply_low) && !sys_reset && !por_active
        && ext_reset_pin_n |=> !sys_reset || por_active || !ext_reset_pin_n || wdog_reset_pulse)
        else $error("brown-out taken without qualification");
    level_two_en_a: assert property (wdog_always_on_fuse |-> ctrl_rdata[EN_BIT])
        else $error("enable reads zero in level two");
    chg_close_a: assert property ($rose(ctrl_rdata[CHG_EN_BIT]) |->
        ##[1:5] !ctrl_rdata[CHG_EN_BIT])
        else $error("change window not closed");
    flag_force_a: assert property (!wdog_always_on_fuse && wdog_reset_flag |-> ctrl_rdata[EN_BIT])
        else $error("enable not forced by reset flag");
    enable_set_a: assert property (ctrl_wr && !sys_reset && ctrl_wdata[EN_BIT]
        |=> ctrl_rdata[EN_BIT])
        else $error("enable write not taken");
    pulse_once_a: assert property (wdog_reset_pulse |=> !wdog_reset_pulse)
        else $error("watchdog reset pulse longer than one cycle");
    pulse_reset_a: assert property (wdog_reset_pulse |-> sys_reset)
        else $error("watchdog pulse without chip reset");
endmodule : wrc_assertions

bind wrc_watchdog_reset_control wrc_assertions #(.STARTUP_CYCLES(STARTUP_CYCLES)) chk_u (
    .core_clk, .rst_n, .por_active, .ext_reset_pin_n, .ext_reset_enable,
    .supply_monitor_enable, .supply_low, .wdog_always_on_fuse, .comparator_ref_select,
    .adc_enable, .ctrl_wr, .ctrl_wdata, .watchdog_restart_instr, .wdog_irq_ack,
    .wdog_reset_flag, .ctrl_rdata, .sys_reset, .wdog_reset_pulse, .wdog_irq, .ref_enable);

// *** dv/wrc_watchdog_reset_control_bench.sv ***
`timescale 1ns/1ps
module wrc_watchdog_reset_control_bench;
    import wrc_pkg::*;
    // Short stretch keeps the run brief
    localparam int SC = 20;
    // Fast watchdog tick so a time-out fits the run; bounds allow for divider phase
    localparam int TD    = 2;
    localparam int WD_HI = TD << BASE_PERIOD_LOG2;
    localparam int WD_LO = WD_HI - TD - 1;
    logic              core_clk, rst_n, por_active, ext_reset_pin_n, ext_reset_enable;
    logic              supply_monitor_enable, supply_low, wdog_always_on_fuse, adc_enable;
    logic              comparator_ref_select, ctrl_wr, watchdog_restart_instr, wdog_irq_ack;
    logic              wdog_reset_flag, sys_reset, wdog_reset_pulse, wdog_irq, ref_enable;
    logic [CTRL_W-1:0] ctrl_wdata, ctrl_rdata;
    int                fail_count = 0;
    int                comparisons = 0;
    int                cyc = 0;

    wrc_watchdog_reset_control #(.STARTUP_CYCLES(SC), .TICK_DIV(TD)) dut_u (
        .core_clk, .rst_n, .por_active, .ext_reset_pin_n, .ext_reset_enable,
        .supply_monitor_enable, .supply_low, .wdog_always_on_fuse, .comparator_ref_select,
        .adc_enable, .ctrl_wr, .ctrl_wdata, .watchdog_restart_instr, .wdog_irq_ack,
        .wdog_reset_flag, .ctrl_rdata, .sys_reset, .wdog_reset_pulse, .wdog_irq, .ref_enable);

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic finish_test();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 25000) begin
            fail_count++;
            finish_test();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask : tick

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Strobe then one idle edge, so back-to-back calls never re-drive in one step
    task automatic wr(input logic [7:0] d);
        ctrl_wr = 1'b1;
        ctrl_wdata = d;
        tick(1);
        ctrl_wr = 1'b0;
        tick(1);
    endtask : wr

    task automatic release_chk(input string nm);
        tick(SC - 1);
        chk(nm, 8'h01, {7'h00, sys_reset});
        tick(1);
        chk(nm, 8'h00, {7'h00, sys_reset});
    endtask : release_chk

    // Waits up to n edges for the reset pulse (sel 0) or the interrupt (sel 1)
    task automatic wait_out(input bit sel, input int n, output int w);
        w = 0;
        while (w < n && (sel ? wdog_irq : wdog_reset_pulse) !== 1'b1) begin
            tick(1);
            w++;
        end
    endtask : wait_out

    initial begin
        int w;
        rst_n = 1'b0;
        por_active = 1'b1;
        ext_reset_pin_n = 1'b1;
        ext_reset_enable = 1'b0;
        supply_monitor_enable = 1'b0;
        supply_low = 1'b0;
        wdog_always_on_fuse = 1'b0;
        comparator_ref_select = 1'b0;
        adc_enable = 1'b0;
        ctrl_wr = 1'b0;
        ctrl_wdata = 8'h00;
        watchdog_restart_instr = 1'b0;
        wdog_irq_ack = 1'b0;
        wdog_reset_flag = 1'b0;
        tick(6);
        rst_n = 1'b1;
        chk("por", 8'h01, {7'h00, sys_reset});
        tick(2);
        por_active = 1'b0;
        release_chk("por_release");
        ext_reset_pin_n = 1'b0;
        tick(1);
        chk("pin_off", 8'h00, {7'h00, sys_reset});
        ext_reset_enable = 1'b1;
        #1;
        chk("pin_on", 8'h01, {7'h00, sys_reset});
        tick(3);
        ext_reset_pin_n = 1'b1;
        release_chk("pin_release");
        for (int i = 0; i < 8; i++) begin
            {supply_monitor_enable, comparator_ref_select, adc_enable} = i[2:0];
            #1;
            chk("ref", {7'h00, |i[2:0]}, {7'h00, ref_enable});
            tick(1);
        end
        comparator_ref_select = 1'b0;
        adc_enable = 1'b0;
        supply_low = 1'b1;
        tick(30);
        chk("bod_short", 8'h00, {7'h00, sys_reset});
        tick(15);
        chk("bod_long", 8'h01, {7'h00, sys_reset});
        supply_low = 1'b0;
        release_chk("bod_release");
        wr(8'h08);
        chk("en_set", 8'h08, ctrl_rdata);
        wr(8'h00);
        chk("en_noclr", 8'h08, ctrl_rdata);
        wr(8'h10);
        wr(8'h00);
        chk("open_no_en", 8'h08, ctrl_rdata);
        wr(8'h18);
        chk("chg_open", 8'h18, ctrl_rdata);
        tick(4);
        chk("chg_closed", 8'h08, ctrl_rdata);
        wr(8'h00);
        chk("late_clr", 8'h08, ctrl_rdata);
        wr(8'h2F);
        chk("period_free", 8'h2F, ctrl_rdata);
        wdog_reset_flag = 1'b1;
        wr(8'h18);
        wr(8'h20);
        chk("flag_block", 8'h28, ctrl_rdata);
        wdog_reset_flag = 1'b0;
        #1;
        chk("flag_kept", 8'h28, ctrl_rdata);
        tick(1);
        wr(8'h18);
        wr(8'h00);
        chk("disable", 8'h00, ctrl_rdata);
        wdog_reset_flag = 1'b1;
        #1;
        chk("flag_force", 8'h08, ctrl_rdata);
        tick(1);
        wdog_reset_flag = 1'b0;
        wr(8'h08);
        wait_out(1'b0, 5000, w);
        chk("wd_period", 8'h01, {7'h00, (w >= WD_LO && w <= WD_HI)});
        chk("wd_pulse", 8'h01, {7'h00, sys_reset});
        tick(1);
        chk("wd_once", 8'h00, {7'h00, wdog_reset_pulse});
        release_chk("wd_release");
        chk("wd_cleared", 8'h00, ctrl_rdata);
        wr(8'h40);
        wait_out(1'b1, 5000, w);
        chk("irq_period", 8'h01, {7'h00, (w >= WD_LO && w <= WD_HI)});
        chk("irq_keep", 8'hC0, ctrl_rdata);
        chk("irq_noreset", 8'h00, {7'h00, sys_reset});
        wdog_irq_ack = 1'b1;
        tick(1);
        wdog_irq_ack = 1'b0;
        chk("irq_ack", 8'h00, {7'h00, wdog_irq});
        wr(8'h48);
        tick(2000);
        watchdog_restart_instr = 1'b1;
        tick(1);
        watchdog_restart_instr = 1'b0;
        wait_out(1'b1, 5000, w);
        chk("restart", 8'h01, {7'h00, (w >= WD_LO && w <= WD_HI)});
        chk("irq_en_clr", 8'h88, ctrl_rdata);
        wr(8'h88);
        chk("flag_wr_clr", 8'h08, ctrl_rdata);
        wait_out(1'b0, 5000, w);
        chk("irq_then_reset", 8'h01, {7'h00, (w >= WD_LO && w <= WD_HI)});
        tick(1);
        release_chk("wd_release2");
        wdog_always_on_fuse = 1'b1;
        #1;
        chk("lvl2_en", 8'h08, ctrl_rdata);
        tick(1);
        wr(8'h01);
        chk("lvl2_noper", 8'h08, ctrl_rdata);
        wr(8'h18);
        wr(8'h03);
        chk("lvl2_per", 8'h0B, ctrl_rdata);
        finish_test();
    end
endmodule : wrc_watchdog_reset_control_bench

// *** rtl/wrc_pkg.sv ***
package wrc_pkg;
    // Clock and derived rates
    localparam int CORE_CLK_HZ        = 20000000;
    localparam int CLK_PERIOD_NS      = 50;
    localparam int WDOG_OSC_HZ        = 128000;
    localparam int WDOG_TICK_DIV      = CORE_CLK_HZ / WDOG_OSC_HZ;
    localparam int WDOG_DIV_W         = 8;

    // Start-up delay (least time, rounded up)
    localparam int STARTUP_DELAY_US     = 64000;
    localparam int STARTUP_DELAY_CYCLES =
        (STARTUP_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STRETCH_W            = 21;

    // Brown-out qualification (least time, rounded up)
    localparam int BROWNOUT_QUALIFY_NS     = 2000;
    localparam int BROWNOUT_QUALIFY_CYCLES =
        (BROWNOUT_QUALIFY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BOD_CNT_W               = 8;

    // Protected-change window
    localparam int CHANGE_WINDOW_CYCLES = 4;
    localparam int WIN_CNT_W            = 3;

    // Watchdog period
    localparam int WDOG_CNT_W       = 20;
    localparam int BASE_PERIOD_LOG2 = 11;
    localparam int PERIOD_CODE_MAX  = 9;

    // Control register layout
    localparam int CTRL_W          = 8;
    localparam int IRQ_FLAG_BIT    = 7;
    localparam int IRQ_EN_BIT      = 6;
    localparam int PERIOD_HI_BIT   = 5;
    localparam int CHG_EN_BIT      = 4;
    localparam int EN_BIT          = 3;
    localparam int PERIOD_LO_MSB   = 2;
    localparam int PERIOD_W        = 4;
    localparam logic [PERIOD_W-1:0] PERIOD_RESET = 4'h0;
endpackage : wrc_pkg

// *** rtl/wrc_watchdog_reset_control.sv ***
`timescale 1ns/1ps
// Functional notes
// - Power-on detector asserts reset immediately
// - Power-on release starts start-up delay
// - Enabled reset pin low resets without clock
// - Pin release waits for start-up delay
// - Low supply resets after qualification, release delayed
// - Brown-out only after minimum qualification time
// - Watchdog reset pulse is one cycle
// - Delay counts from watchdog pulse trailing edge
// - Reference on for monitor, comparator or converter
// - Watchdog counts 128 kHz ticks
// - Restart instruction clears watchdog counter
// - Counter cleared on disable and reset
// - Ten selectable time-out periods
// - Unrestarted time-out resets the device
// - Time-out may raise interrupt instead
// - Fuse picks safety level one or two
// - Level one enables freely
// - Level one disable needs timed two-write sequence
// - Level two always runs, enable reads one
// - Level two period change needs timed sequence
// - Change-enable clears four cycles after set
// - Interrupt with enable clears interrupt-enable
// - Periods double 2048 to 1048576, reserved mapped
// - Level one enable forced by reset flag
module wrc_watchdog_reset_control
    import wrc_pkg::*;
#(
    parameter int STARTUP_CYCLES = wrc_pkg::STARTUP_DELAY_CYCLES,
    parameter int TICK_DIV       = wrc_pkg::WDOG_TICK_DIV
) (
    // Clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      rst_n,
    // Reset sources
    input  wire logic                      por_active,
    input  wire logic                      ext_reset_pin_n,
    input  wire logic                      ext_reset_enable,
    input  wire logic                      supply_monitor_enable,
    input  wire logic                      supply_low,
    // Fuses and reference requests
    input  wire logic                      wdog_always_on_fuse,
    input  wire logic                      comparator_ref_select,
    input  wire logic                      adc_enable,
    // Processor side
    input  wire logic                      ctrl_wr,
    input  wire logic [wrc_pkg::CTRL_W-1:0] ctrl_wdata,
    input  wire logic                      watchdog_restart_instr,
    input  wire logic                      wdog_irq_ack,
    input  wire logic                      wdog_reset_flag,
    // Outputs
    output logic      [wrc_pkg::CTRL_W-1:0] ctrl_rdata,
    output logic                           sys_reset,
    output logic                           wdog_reset_pulse,
    output logic                           wdog_irq,
    output logic                           ref_enable
);
    import wrc_pkg::*;

    // Terminal count of a period code; reserved codes fall back to the shortest
    function automatic logic [WDOG_CNT_W-1:0] period_last(input logic [PERIOD_W-1:0] code);
        logic [4:0] shift;
        shift = (int'(code) > PERIOD_CODE_MAX) ? 5'(BASE_PERIOD_LOG2)
                                               : 5'(BASE_PERIOD_LOG2 + int'(code));
        period_last = WDOG_CNT_W'((64'h1 << shift) - 64'h1);
    endfunction : period_last

    // State
    logic [STRETCH_W-1:0]  stretch_q;
    logic [STRETCH_W-1:0]  stretch_d;
    logic [BOD_CNT_W-1:0]  bod_cnt_q;
    logic [BOD_CNT_W-1:0]  bod_cnt_d;
    logic [WDOG_DIV_W-1:0] div_q;
    logic [WDOG_DIV_W-1:0] div_d;
    logic [WDOG_CNT_W-1:0] wcnt_q;
    logic [WDOG_CNT_W-1:0] wcnt_d;
    logic [WIN_CNT_W-1:0]  win_cnt_q;
    logic [WIN_CNT_W-1:0]  win_cnt_d;
    logic [PERIOD_W-1:0]   period_q;
    logic [PERIOD_W-1:0]   period_d;
    logic                  en_q;
    logic                  en_d;
    logic                  chg_q;
    logic                  chg_d;
    logic                  irq_en_q;
    logic                  irq_en_d;
    logic                  flag_q;
    logic                  flag_d;
    logic                  pulse_q;
    logic                  pulse_d;

    // Decoded terms
    logic                  pin_rst;
    logic                  bod_rst;
    logic                  src_active;
    logic                  tick;
    logic                  eff_en;
    logic                  running;
    logic                  timeout;
    logic                  w_chg;
    logic                  w_en;
    logic                  w_flag;
    logic                  w_irq_en;
    logic [PERIOD_W-1:0]   w_period;
    logic                  open_seq;
    logic                  close_seq;
    logic                  level2;

    assign w_chg    = ctrl_wdata[CHG_EN_BIT];
    assign w_en     = ctrl_wdata[EN_BIT];
    assign w_flag   = ctrl_wdata[IRQ_FLAG_BIT];
    assign w_irq_en = ctrl_wdata[IRQ_EN_BIT];
    assign w_period = {ctrl_wdata[PERIOD_HI_BIT], ctrl_wdata[PERIOD_LO_MSB:0]};
    assign level2   = wdog_always_on_fuse;

    // Opening write must carry both change-enable and enable
    assign open_seq  = ctrl_wr & w_chg & w_en;
    // Second write lands inside the window with change-enable clear
    assign close_seq = ctrl_wr & chg_q & ~w_chg;

    // Reset sources combine without the clock so reset holds with no clock
    assign pin_rst    = ext_reset_enable & ~ext_reset_pin_n;
    assign bod_rst    = supply_monitor_enable & supply_low &
                        (int'(bod_cnt_q) > BROWNOUT_QUALIFY_CYCLES);
    assign src_active = por_active | pin_rst | bod_rst | pulse_q;
    assign sys_reset  = src_active | (stretch_q != '0);
    assign wdog_reset_pulse = pulse_q;

    assign ref_enable = supply_monitor_enable | comparator_ref_select | adc_enable;

    // Start-up stretch reloads while any source is active, counts after
    always_comb begin
        if (src_active) begin
            stretch_d = STRETCH_W'(STARTUP_CYCLES);
        end else if (stretch_q != '0) begin
            stretch_d = stretch_q - STRETCH_W'(1);
        end else begin
            stretch_d = stretch_q;
        end
    end

    // Dips shorter than the qualify time never reach the reset
    always_comb begin
        if (!(supply_monitor_enable & supply_low)) begin
            bod_cnt_d = '0;
        end else if (int'(bod_cnt_q) <= BROWNOUT_QUALIFY_CYCLES) begin
            bod_cnt_d = bod_cnt_q + BOD_CNT_W'(1);
        end else begin
            bod_cnt_d = bod_cnt_q;
        end
    end

    // 128 kHz tick enable from the core clock
    assign tick  = (div_q == WDOG_DIV_W'(TICK_DIV - 1));
    assign div_d = tick ? '0 : div_q + WDOG_DIV_W'(1);

    // Level two forces the enable; level one follows the reset flag too
    assign eff_en  = level2 | en_q | wdog_reset_flag;
    assign running = eff_en | irq_en_q;
    assign timeout = tick & running & (wcnt_q == period_last(period_q));

    // Counter only advances on the tick; clears by reset, restart or stop take hold on any edge
    always_comb begin
        if (sys_reset | watchdog_restart_instr | ~running) begin
            wcnt_d = '0;
        end else if (timeout) begin
            wcnt_d = '0;
        end else if (tick) begin
            wcnt_d = wcnt_q + WDOG_CNT_W'(1);
        end else begin
            wcnt_d = wcnt_q;
        end
    end

    // Reset pulse lasts one cycle: the reset it causes clears the counter
    assign pulse_d = timeout & eff_en & ~irq_en_q;

    // Change-enable window
    always_comb begin
        chg_d     = chg_q;
        win_cnt_d = win_cnt_q;
        if (open_seq) begin
            chg_d     = 1'b1;
            win_cnt_d = WIN_CNT_W'(CHANGE_WINDOW_CYCLES - 1);
        end else if (ctrl_wr & ~w_chg) begin
            chg_d     = 1'b0;
        end else if (chg_q) begin
            if (win_cnt_q == '0) begin
                chg_d = 1'b0;
            end else begin
                win_cnt_d = win_cnt_q - WIN_CNT_W'(1);
            end
        end
    end

    // Enable bit
    always_comb begin
        en_d = en_q;
        if (ctrl_wr && !level2) begin
            if (w_en) begin
                en_d = 1'b1;
            end else if (close_seq && !wdog_reset_flag) begin
                en_d = 1'b0;
            end
        end
    end

    // Period: free in level one, timed in level two
    always_comb begin
        period_d = period_q;
        if (ctrl_wr && !level2) begin
            period_d = w_period;
        end else if (close_seq && level2) begin
            period_d = w_period;
        end
    end

    // Interrupt enable; a write in the same cycle as the hardware clear wins
    always_comb begin
        irq_en_d = irq_en_q;
        if (timeout && irq_en_q && eff_en) begin
            irq_en_d = 1'b0;
        end
        if (ctrl_wr) begin
            irq_en_d = w_irq_en;
        end
    end

    // Time-out flag: set beats clear
    always_comb begin
        flag_d = flag_q;
        if ((ctrl_wr && w_flag) || wdog_irq_ack) begin
            flag_d = 1'b0;
        end
        if (timeout && irq_en_q) begin
            flag_d = 1'b1;
        end
    end

    assign wdog_irq = flag_q;

    assign ctrl_rdata = {flag_q, irq_en_q, period_q[3], chg_q, eff_en,
                         period_q[2:0]};

    // Free-running parts: only the power-on async reset clears them
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stretch_q <= '0;
        end else begin
            stretch_q <= stretch_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bod_cnt_q <= '0;
        end else begin
            bod_cnt_q <= bod_cnt_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= pulse_d;
        end
    end

    // Watchdog counter
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wcnt_q <= '0;
        end else begin
            wcnt_q <= wcnt_d;
        end
    end

    // Control state returns to initial values under any chip reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_q <= 1'b0;
        end else if (sys_reset) begin
            en_q <= 1'b0;
        end else begin
            en_q <= en_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            chg_q <= 1'b0;
        end else if (sys_reset) begin
            chg_q <= 1'b0;
        end else begin
            chg_q <= chg_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            win_cnt_q <= '0;
        end else if (sys_reset) begin
            win_cnt_q <= '0;
        end else begin
            win_cnt_q <= win_cnt_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            period_q <= PERIOD_RESET;
        end else if (sys_reset) begin
            period_q <= PERIOD_RESET;
        end else begin
            period_q <= period_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_en_q <= 1'b0;
        end else if (sys_reset) begin
            irq_en_q <= 1'b0;
        end else begin
            irq_en_q <= irq_en_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else if (sys_reset) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end
endmodule : wrc_watchdog_reset_control
